// *** design/qd_encoder_ctrl.sv ***
// Purpose: quadrature decoder position counter, auxiliary timer, input filters and interrupt flag, APB slave
// Assumes: pins are asynchronous and pass two flops; cpu_idle comes from logic on pclk
// Notes: one module; registers answer with pready one cycle after the setup cycle
//
// The placing of the registers and register access over APB were left to the implementer.
module qd_encoder_ctrl
  import qd_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phase_a_pin,
  input wire logic phase_b_pin,
  input wire logic index_pin,
  input wire logic cpu_idle,
  output logic irq,
  output logic direction_out,
  output logic direction_oe_n
);
  if (ADDR_W < 5) begin : g_chk
    $error("qd_encoder_ctrl: ADDR_W must be at least 5");
  end

  qd_ctrl_s ctrl_r, ctrl_nxt;
  qd_filt_s filt_r;
  logic [15:0] pos_r, pos_nxt, max_r;
  logic irq_flag_r, irq_en_r;
  qd_pins_s pin_s1_r, pin_s2_r, flt_r, prev_r;
  logic [1:0] flt_cnt_r [3];
  logic [7:0] fdiv_cnt_r, pre_cnt_r;
  logic pready_r, pslverr_r, irq_r, dir_out_r, dir_oe_n_r;
  logic [31:0] prdata_r;

  // ---------------- bus side ----------------
  logic acc, wr;
  logic [4:0] ofs;
  logic [1:0] strb;
  logic mapped;
  assign ofs = paddr[4:0];
  assign strb = pstrb[1:0];
  assign mapped = (paddr[ADDR_W-1:5] == '0) && (ofs == OFS_CTRL || ofs == OFS_FILT || ofs == OFS_POS
                  || ofs == OFS_MAX || ofs == OFS_IRQ);
  assign acc = psel && penable && pready_r;
  assign wr = acc && pwrite && !pslverr_r;

  // answer one cycle after setup; read data is a snapshot taken at the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= !mapped;
      prdata_r <= 32'h0000_0000;
      if (!pwrite && mapped) begin
        case (ofs)
          OFS_CTRL: prdata_r[15:0] <= ctrl_r | {3'b000, pin_s2_r.index, 12'h000};
          OFS_FILT: prdata_r[15:0] <= filt_r;
          OFS_POS: prdata_r[15:0] <= pos_r;
          OFS_MAX: prdata_r[15:0] <= max_r;
          default: prdata_r[1:0] <= {irq_en_r, irq_flag_r};
        endcase
      end
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // ---------------- pin inputs ----------------
  // two-flop synchroniser; only the second stage is looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {index_pin, phase_b_pin, phase_a_pin};
      pin_s2_r <= pin_s1_r;
    end
  end

  // filter clock divider
  logic ftick;
  assign ftick = (fdiv_cnt_r == qd_filt_div(filt_r.filter_clock_divide));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fdiv_cnt_r <= 8'h00;
    end else if (ftick) begin
      fdiv_cnt_r <= 8'h00;
    end else begin
      fdiv_cnt_r <= fdiv_cnt_r + 8'h01;
    end
  end

  // three-sample stability filter per channel; a glitch restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_r <= '0;
      for (int i = 0; i < 3; i++) begin
        flt_cnt_r[i] <= 2'h0;
      end
    end else if (ftick) begin
      for (int i = 0; i < 3; i++) begin
        if (pin_s2_r[i] == flt_r[i]) begin
          flt_cnt_r[i] <= 2'h0;
        end else if (flt_cnt_r[i] == FILT_LAST) begin
          flt_r[i] <= pin_s2_r[i];
          flt_cnt_r[i] <= 2'h0;
        end else begin
          flt_cnt_r[i] <= flt_cnt_r[i] + 2'h1;
        end
      end
    end
  end

  // decoder inputs: filtered or raw, then optional swap
  qd_pins_s pick, cur;
  always_comb begin
    pick = filt_r.filter_output_enable ? flt_r : pin_s2_r;
    cur = pick;
    if (ctrl_r.phase_swap) begin
      cur.phase_a = pick.phase_b;
      cur.phase_b = pick.phase_a;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= cur;
    end
  end

  // ---------------- decode ----------------
  qd_mode_e mode;
  logic run, enc, idxmode, matchmode, x4, step, up, idx_ok, tmode, ttick, tsrc, tdir, gate_fall;
  assign mode = ctrl_r.encoder_mode_select;
  assign run = !(cpu_idle && ctrl_r.stop_in_idle);
  assign enc = mode[2];
  assign x4 = enc && mode[1];
  assign idxmode = enc && !mode[0];
  assign matchmode = enc && mode[0];
  assign tmode = (mode == QD_TIMER);
  // x4 counts every edge of both phases, x2 only phase A edges
  assign step = x4 ? ((cur.phase_a ^ prev_r.phase_a) || (cur.phase_b ^ prev_r.phase_b))
                   : (cur.phase_a ^ prev_r.phase_a);
  assign up = cur.phase_a ^ prev_r.phase_b;
  always_comb begin
    idx_ok = 1'b0;
    if (cur.index && !prev_r.index) begin
      if (x4) begin
        idx_ok = (cur.phase_b == filt_r.index_match_value[1])
                 && (cur.phase_a == filt_r.index_match_value[0]);
      end else begin
        idx_ok = ((filt_r.index_match_value[1] ? cur.phase_b : cur.phase_a)
                 == filt_r.index_match_value[0]);
      end
    end
  end

  // timer source: every cycle or phase A rising edge; gating needs phase A high
  assign tsrc = ctrl_r.timer_clock_source ? (cur.phase_a && !prev_r.phase_a)
               : (!ctrl_r.gated_accumulation_enable || cur.phase_a);
  assign gate_fall = tmode && ctrl_r.gated_accumulation_enable && !ctrl_r.timer_clock_source
                     && !cur.phase_a && prev_r.phase_a;
  assign ttick = tmode && run && tsrc && (pre_cnt_r == qd_pre_div(ctrl_r.timer_prescale_select));
  assign tdir = ctrl_r.direction_source_select ? cur.phase_b : ctrl_r.count_direction;

  // prescaler only advances in timer mode, so encoder modes ignore it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 8'h00;
    end else if (!tmode) begin
      pre_cnt_r <= 8'h00;
    end else if (run && tsrc) begin
      pre_cnt_r <= ttick ? 8'h00 : pre_cnt_r + 8'h01;
    end
  end

  // ---------------- counter ----------------
  logic ev_roll, ev_idx, ev_err, ev_per, ev_set;
  always_comb begin
    pos_nxt = pos_r;
    ev_roll = 1'b0;
    ev_idx = 1'b0;
    ev_err = 1'b0;
    ev_per = 1'b0;
    if (run && enc && step) begin
      if (up) begin
        if (matchmode && pos_r == max_r) begin
          pos_nxt = POS_RST;
          ev_roll = 1'b1;
        end else begin
          pos_nxt = pos_r + 16'h0001;
        end
      end else if (matchmode && pos_r == POS_RST) begin
        pos_nxt = max_r;
        ev_roll = 1'b1;
      end else begin
        pos_nxt = pos_r - 16'h0001;
      end
      // counting carries on after an error
      if (idxmode && pos_nxt == (up ? max_r + 16'h0001 : ALL_ONES)) begin
        ev_err = 1'b1;
      end
    end
    if (run && enc && idx_ok) begin
      ev_idx = 1'b1;
      if (idxmode && ctrl_r.index_reset_enable) begin
        pos_nxt = POS_RST;
      end
    end
    if (ttick) begin
      if (tdir && pos_r == max_r) begin
        pos_nxt = POS_RST;
        ev_per = 1'b1;
      end else if (!tdir && pos_r == POS_RST) begin
        pos_nxt = max_r;
        ev_per = 1'b1;
      end else begin
        pos_nxt = tdir ? pos_r + 16'h0001 : pos_r - 16'h0001;
      end
    end
    if (wr && ofs == OFS_POS) begin
      pos_nxt = qd_merge(pos_r, pwdata[15:0], strb);
    end
  end
  assign ev_set = ev_roll || ev_idx || (ev_err && !filt_r.count_error_irq_disable)
                  || ev_per || (gate_fall && run);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_r <= POS_RST;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // ---------------- registers ----------------
  // control: written bits, then hardware status; hardware error set beats a clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr && ofs == OFS_CTRL) begin
      ctrl_nxt = qd_merge(ctrl_r, pwdata[15:0], strb) & CTRL_WMASK;
      if (!tmode) begin
        ctrl_nxt.count_direction = ctrl_r.count_direction;
      end
    end
    if (ev_err) begin
      ctrl_nxt.count_error_flag = 1'b1;
    end
    if (run && enc && step) begin
      ctrl_nxt.count_direction = up;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_r <= FILT_RST;
      max_r <= MAX_RST;
    end else if (wr && ofs == OFS_FILT) begin
      filt_r <= qd_merge(filt_r, pwdata[15:0], strb) & FILT_WMASK;
    end else if (wr && ofs == OFS_MAX) begin
      max_r <= qd_merge(max_r, pwdata[15:0], strb);
    end
  end

  // interrupt flag: write one to clear; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_r <= 1'b0;
      irq_en_r <= 1'b0;
    end else begin
      if (ev_set) begin
        irq_flag_r <= 1'b1;
      end else if (wr && ofs == OFS_IRQ && strb[0] && pwdata[IRQ_FLAG_BIT]) begin
        irq_flag_r <= 1'b0;
      end
      if (wr && ofs == OFS_IRQ && strb[0]) begin
        irq_en_r <= pwdata[IRQ_EN_BIT];
      end
    end
  end

  // registered pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
      dir_out_r <= 1'b0;
      dir_oe_n_r <= 1'b1;
    end else begin
      irq_r <= irq_flag_r && irq_en_r;
      dir_out_r <= ctrl_r.count_direction;
      dir_oe_n_r <= !ctrl_r.direction_pin_output_enable;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign direction_out = dir_out_r;
  assign direction_oe_n = dir_oe_n_r;

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_flag_set;
    ev_set |=> irq_flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event did not set the flag");
  property p_flag_sticky;
    irq_flag_r && !(wr && ofs == OFS_IRQ) |=> irq_flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without software");
  property p_irq_gate;
    !irq_en_r [*2] |-> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
  property p_err_mode;
    $rose(ctrl_r.count_error_flag) && !$past(wr && ofs == OFS_CTRL) |-> $past(idxmode);
  endproperty
  a_err_mode: assert property (p_err_mode) else $error("count error outside index modes");
  property p_idle_halt;
    cpu_idle && ctrl_r.stop_in_idle && !(wr && ofs == OFS_POS) |=> pos_r == $past(pos_r);
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("count moved while halted");
  property p_idx_reset;
    run && idxmode && idx_ok && ctrl_r.index_reset_enable && !(wr && ofs == OFS_POS) |=> pos_r == POS_RST;
  endproperty
  a_idx_reset: assert property (p_idx_reset) else $error("index did not clear count");
  property p_match;
    run && matchmode && step && up && pos_r == max_r && !idx_ok && !(wr && ofs == OFS_POS)
      |=> pos_r == POS_RST && irq_flag_r;
  endproperty
  a_match: assert property (p_match) else $error("match reset missing");
  property p_filter;
    $changed(flt_r.phase_a) |-> $past(flt_cnt_r[0]) == FILT_LAST && $past(ftick);
  endproperty
  a_filter: assert property (p_filter) else $error("filter changed too early");
  property p_dir_pin;
    ctrl_r.direction_pin_output_enable [*2] |-> !direction_oe_n;
  endproperty
  a_dir_pin: assert property (p_dir_pin) else $error("direction pin not driven");
  c_index: cover property (run && idxmode && idx_ok);
  c_err: cover property ($rose(ctrl_r.count_error_flag));
  c_period: cover property (ev_per);
  c_gate: cover property (gate_fall && run);
endmodule : qd_encoder_ctrl

// *** design/qd_pkg.sv ***
// Purpose: shared constants, field layouts and types of the quadrature decoder control block
// Assumes: 16-bit registers, each in one aligned 32-bit APB word
// Notes: divide tables are functions so the decoder and the bus side agree on them
package qd_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_FILT = 5'h04;
  localparam logic [4:0] OFS_POS = 5'h08;
  localparam logic [4:0] OFS_MAX = 5'h0C;
  localparam logic [4:0] OFS_IRQ = 5'h10;
  // interrupt register bit positions
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] FILT_RST = 16'h0000;
  localparam logic [15:0] POS_RST = 16'h0000;
  localparam logic [15:0] MAX_RST = 16'hFFFF;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
  // writable bit masks; reserved and read-only bits stay zero in storage
  localparam logic [15:0] CTRL_WMASK = 16'hAFFF;
  localparam logic [15:0] FILT_WMASK = 16'h07F0;
  // a filter commits on the third equal sample: count 0, 1, then 2
  localparam logic [1:0] FILT_LAST = 2'h2;

  typedef enum logic [2:0] {
    QD_OFF = 3'b000,
    QD_TIMER = 3'b001,
    QD_UNUSED2 = 3'b010,
    QD_UNUSED3 = 3'b011,
    QD_X2_INDEX = 3'b100,
    QD_X2_MATCH = 3'b101,
    QD_X4_INDEX = 3'b110,
    QD_X4_MATCH = 3'b111
  } qd_mode_e;

  typedef struct packed {
    logic count_error_flag;
    logic rsv14;
    logic stop_in_idle;
    logic index_level;
    logic count_direction;
    qd_mode_e encoder_mode_select;
    logic phase_swap;
    logic direction_pin_output_enable;
    logic gated_accumulation_enable;
    logic [1:0] timer_prescale_select;
    logic index_reset_enable;
    logic timer_clock_source;
    logic direction_source_select;
  } qd_ctrl_s;

  typedef struct packed {
    logic [4:0] rsv15;
    logic [1:0] index_match_value;
    logic count_error_irq_disable;
    logic filter_output_enable;
    logic [2:0] filter_clock_divide;
    logic [3:0] rsv3;
  } qd_filt_s;

  typedef struct packed {
    logic index;
    logic phase_b;
    logic phase_a;
  } qd_pins_s;

  // filter clock divide minus one: 1,2,4,16,32,64,128,256
  function automatic logic [7:0] qd_filt_div(input logic [2:0] code);
    case (code)
      3'h0: qd_filt_div = 8'h00;
      3'h1: qd_filt_div = 8'h01;
      3'h2: qd_filt_div = 8'h03;
      3'h3: qd_filt_div = 8'h0F;
      3'h4: qd_filt_div = 8'h1F;
      3'h5: qd_filt_div = 8'h3F;
      3'h6: qd_filt_div = 8'h7F;
      default: qd_filt_div = 8'hFF;
    endcase
  endfunction : qd_filt_div

  // timer prescale minus one: 1,8,64,256
  function automatic logic [7:0] qd_pre_div(input logic [1:0] code);
    case (code)
      2'h0: qd_pre_div = 8'h00;
      2'h1: qd_pre_div = 8'h07;
      2'h2: qd_pre_div = 8'h3F;
      default: qd_pre_div = 8'hFF;
    endcase
  endfunction : qd_pre_div

  // merge a 16-bit write under the two low byte strobes
  function automatic logic [15:0] qd_merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] strb);
    qd_merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction : qd_merge
endpackage : qd_pkg

// *** verification/qd_enc_model.sv ***
// Purpose: behavioural incremental encoder with index channel, facing the decoder pins
// Assumes: one step request at a time; index is raised by the bench while both phases are low
// Notes: pins are always driven, as on a push-pull encoder, so there is no released state to model
module qd_enc_model
  import qd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step_fwd,
  input wire logic step_rev,
  input wire logic index_hold,
  input wire logic glitch_a,
  output qd_pins_s pins
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] phase_r;

  // quarter-cycle position; forward means phase A leads phase B
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 2'h0;
    end else if (step_fwd) begin
      phase_r <= phase_r + 2'h1;
    end else if (step_rev) begin
      phase_r <= phase_r - 2'h1;
    end
  end

  // gray sequence (a,b): 00, 10, 11, 01; a glitch flips phase A for one cycle only
  always_comb begin
    pins.phase_a = (phase_r == 2'h1 || phase_r == 2'h2) ^ glitch_a;
    pins.phase_b = phase_r[1];
    pins.index = index_hold; // bench raises it only with both phases low
  end
endmodule : qd_enc_model

// *** verification/quadrature_decoder_control_tb.sv ***
// Purpose: self-checking bench for the quadrature decoder control block over APB
// Assumes: pready answers within a few cycles; encoder steps are spaced wide enough to settle
// Notes: timer counts are checked against windows, since start and stop land on bus transfers; the prescaler clears outside timer mode
module quadrature_decoder_control_tb
  import qd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cpu_idle = 1'b0;
  logic irq;
  logic direction_out;
  logic direction_oe_n;
  logic step_fwd = 1'b0;
  logic step_rev = 1'b0;
  logic index_hold = 1'b0;
  logic glitch_a = 1'b0;
  qd_pins_s pins;
  int fail_count = 0;
  int n_compared = 0;
  logic [31:0] rdat;
  logic rerr;

  // index cases: control, filter, position after the pulse, flag after the pulse
  localparam logic [15:0] IDX_CTRL [5] = '{16'h0604, 16'h0604, 16'h0600, 16'h0404, 16'h0404};
  localparam logic [15:0] IDX_FILT [5] = '{16'h0000, 16'h0600, 16'h0000, 16'h0400, 16'h0600};
  localparam logic [15:0] IDX_POS [5] = '{16'h0000, 16'h0004, 16'h0004, 16'h0000, 16'h0002};
  localparam logic [15:0] IDX_FLG [5] = '{16'h0001, 16'h0000, 16'h0001, 16'h0001, 16'h0000};

  always #2 pclk = ~pclk;

  qd_encoder_ctrl qd_encoder_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase_a_pin(pins.phase_a), .phase_b_pin(pins.phase_b),
    .index_pin(pins.index), .cpu_idle(cpu_idle), .irq(irq), .direction_out(direction_out),
    .direction_oe_n(direction_oe_n)
  );

  qd_enc_model qd_enc_model_inst (
    .pclk(pclk), .presetn(presetn), .step_fwd(step_fwd), .step_rev(step_rev),
    .index_hold(index_hold), .glitch_a(glitch_a), .pins(pins)
  );

  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer: setup, access held until pready, then release and one idle edge
  task automatic xfer(input logic wr_en, input logic [4:0] a, input logic [15:0] wd, input logic [1:0] st,
                      output logic [31:0] d, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= {3'h0, a};
    pwdata <= {16'h0000, wd};
    pstrb <= {2'b00, st};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      fail_count++;
      $display("Error at %0t: bus transfer never answered", $time);
      print_verdict();
    end
  endtask : xfer

  task automatic wr(input logic [4:0] a, input logic [15:0] wd, input logic [1:0] st = 2'b11);
    logic [31:0] d;
    logic e;
    xfer(1'b1, a, wd, st, d, e);
  endtask : wr

  // masked read compare; the upper half must always read zero
  task automatic rdc(input logic [4:0] a, input logic [15:0] mask, input logic [15:0] exp);
    logic [31:0] d;
    logic e;
    xfer(1'b0, a, 16'h0000, 2'b11, d, e);
    chk(d & {16'hFFFF, mask}, {16'h0000, exp});
  endtask : rdc

  // window compare for free-running timer counts
  task automatic rdr(input logic [4:0] a, input logic [15:0] lo, input logic [15:0] hi);
    logic [31:0] d;
    logic e;
    xfer(1'b0, a, 16'h0000, 2'b11, d, e);
    n_compared++;
    if ((d[15:0] >= lo && d[15:0] <= hi) !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: count %h outside %h..%h", $time, d[15:0], lo, hi);
    end
  endtask : rdr

  // encoder quarter steps, spaced so sync and decode settle between them
  task automatic step(input logic fwd, input int k);
    repeat (k) begin
      if (fwd) begin
        step_fwd <= 1'b1;
      end else begin
        step_rev <= 1'b1;
      end
      @(posedge pclk);
      step_fwd <= 1'b0;
      step_rev <= 1'b0;
      repeat (12) @(posedge pclk);
    end
  endtask : step

  task automatic pulse_a(input int k);
    repeat (k) begin
      glitch_a <= 1'b1;
      @(posedge pclk);
      glitch_a <= 1'b0;
      repeat (12) @(posedge pclk);
    end
  endtask : pulse_a

  // hang guard: the whole run is far shorter than this
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    $display("Error at %0t: run did not finish", $time);
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset state of every register and of direction_oe_n
    rdc(OFS_CTRL, 16'hFFFF, 16'h0000);
    rdc(OFS_FILT, 16'hFFFF, 16'h0000);
    rdc(OFS_POS, 16'hFFFF, 16'h0000);
    rdc(OFS_MAX, 16'hFFFF, 16'hFFFF);
    rdc(OFS_IRQ, 16'hFFFF, 16'h0000);
    chk({31'h0, direction_oe_n}, 32'h0000_0001);
    xfer(1'b0, 5'h14, 16'h0000, 2'b11, rdat, rerr);
    chk({rdat[31:1], rerr}, 32'h0000_0001);
    // byte lanes land separately; reserved bits stay zero
    wr(OFS_FILT, 16'hFFFF, 2'b01);
    rdc(OFS_FILT, 16'hFFFF, 16'h00F0);
    wr(OFS_FILT, 16'hFFFF, 2'b10);
    rdc(OFS_FILT, 16'hFFFF, 16'h07F0);
    wr(OFS_FILT, 16'h0000);
    wr(OFS_POS, 16'h1234, 2'b10);
    rdc(OFS_POS, 16'hFFFF, 16'h1200);
    // x4 counting, direction status and pin
    wr(OFS_POS, 16'h0000);
    wr(OFS_CTRL, 16'h0700);
    step(1'b1, 5);
    rdc(OFS_POS, 16'hFFFF, 16'h0005);
    rdc(OFS_CTRL, 16'h0800, 16'h0800);
    step(1'b0, 2);
    rdc(OFS_POS, 16'hFFFF, 16'h0003);
    wr(OFS_CTRL, 16'h0F40);
    rdc(OFS_CTRL, 16'h0840, 16'h0040);
    chk({30'h0, direction_oe_n, direction_out}, 32'h0000_0000);
    step(1'b1, 1);
    chk({30'h0, direction_oe_n, direction_out}, 32'h0000_0001);
    // swapped phases count the other way and underflow raises the flag
    wr(OFS_IRQ, 16'h0001);
    wr(OFS_POS, 16'h0000);
    wr(OFS_CTRL, 16'h0780);
    step(1'b1, 4);
    rdc(OFS_POS, 16'hFFFF, 16'hFFFC);
    rdc(OFS_IRQ, 16'h0001, 16'h0001);
    // x2 counts phase A edges only
    wr(OFS_POS, 16'h0000);
    wr(OFS_CTRL, 16'h0500);
    step(1'b1, 4);
    rdc(OFS_POS, 16'hFFFF, 16'h0002);
    // match reset, flag hold, enable gating and clear
    wr(OFS_IRQ, 16'h0001);
    wr(OFS_MAX, 16'h0003);
    wr(OFS_POS, 16'h0000);
    wr(OFS_CTRL, 16'h0700);
    step(1'b1, 4);
    rdc(OFS_POS, 16'hFFFF, 16'h0000);
    repeat (50) @(posedge pclk);
    rdc(OFS_IRQ, 16'h0003, 16'h0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(OFS_IRQ, 16'h0002);
    @(posedge pclk); // irq is registered one cycle after the enable lands
    chk({31'h0, irq}, 32'h0000_0001);
    rdc(OFS_IRQ, 16'h0003, 16'h0003);
    wr(OFS_IRQ, 16'h0003);
    rdc(OFS_IRQ, 16'h0003, 16'h0002);
    chk({31'h0, irq}, 32'h0000_0000);
    // index qualification table, with the index level read mid-pulse
    wr(OFS_MAX, 16'hFFFF);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_IRQ, 16'h0001);
      wr(OFS_FILT, IDX_FILT[i]);
      wr(OFS_CTRL, IDX_CTRL[i]);
      wr(OFS_POS, 16'h0000);
      step(1'b1, 4);
      index_hold <= 1'b1;
      repeat (8) @(posedge pclk);
      rdc(OFS_CTRL, 16'h1000, 16'h1000);
      index_hold <= 1'b0;
      repeat (8) @(posedge pclk);
      rdc(OFS_POS, 16'hFFFF, IDX_POS[i]);
      rdc(OFS_IRQ, 16'h0001, IDX_FLG[i]);
    end
    rdc(OFS_CTRL, 16'h1000, 16'h0000);
    // count error: flag set, interrupt masked, software clear, then unmasked
    wr(OFS_IRQ, 16'h0001);
    wr(OFS_MAX, 16'h0003);
    wr(OFS_FILT, 16'h0100);
    wr(OFS_CTRL, 16'h0600);
    wr(OFS_POS, 16'h0000);
    step(1'b1, 4);
    rdc(OFS_CTRL, 16'h8000, 16'h8000);
    rdc(OFS_IRQ, 16'h0001, 16'h0000);
    wr(OFS_POS, 16'h0000);
    wr(OFS_CTRL, 16'h0600);
    rdc(OFS_CTRL, 16'h8000, 16'h0000);
    wr(OFS_FILT, 16'h0000);
    step(1'b1, 4);
    rdc(OFS_IRQ, 16'h0001, 16'h0001);
    // timer: rate, prescale, phase B direction and stop in idle with the cpu idle, then the period flag with the cpu awake
    wr(OFS_IRQ, 16'h0001);
    wr(OFS_MAX, 16'hFFFF);
    cpu_idle <= 1'b1;
    wr(OFS_POS, 16'h0000);
    wr(OFS_CTRL, 16'h0900);
    repeat (100) @(posedge pclk);
    wr(OFS_CTRL, 16'h0800); // stop with direction up; the bit is only writable while in timer mode
    rdr(OFS_POS, 16'h0064, 16'h006A);
    wr(OFS_POS, 16'h0000);
    wr(OFS_CTRL, 16'h0908);
    repeat (160) @(posedge pclk);
    wr(OFS_CTRL, 16'h0800);
    rdr(OFS_POS, 16'h0013, 16'h0016);
    wr(OFS_POS, 16'h03E8);
    wr(OFS_CTRL, 16'h0901);
    repeat (100) @(posedge pclk);
    wr(OFS_CTRL, 16'h0800);
    rdr(OFS_POS, 16'h037E, 16'h0384);
    wr(OFS_POS, 16'h0000);
    wr(OFS_CTRL, 16'h2900);
    repeat (100) @(posedge pclk);
    wr(OFS_CTRL, 16'h0800);
    rdc(OFS_POS, 16'hFFFF, 16'h0000);
    cpu_idle <= 1'b0;
    wr(OFS_MAX, 16'h0007);
    wr(OFS_CTRL, 16'h0900);
    repeat (20) @(posedge pclk);
    wr(OFS_CTRL, 16'h0800);
    rdc(OFS_IRQ, 16'h0001, 16'h0001);
    wr(OFS_MAX, 16'hFFFF);
    // gated accumulation: counts only while phase A is high, its fall sets the flag
    wr(OFS_IRQ, 16'h0001);
    wr(OFS_POS, 16'h0000);
    wr(OFS_CTRL, 16'h0920);
    step(1'b1, 3);
    wr(OFS_CTRL, 16'h0800);
    rdr(OFS_POS, 16'h0018, 16'h001C);
    rdc(OFS_IRQ, 16'h0001, 16'h0001);
    step(1'b1, 1);
    // external clock on phase A: short pulses count raw, are rejected when filtered
    wr(OFS_POS, 16'h0000);
    wr(OFS_CTRL, 16'h0902);
    pulse_a(3);
    rdc(OFS_POS, 16'hFFFF, 16'h0003);
    wr(OFS_FILT, 16'h0080);
    pulse_a(3);
    rdc(OFS_POS, 16'hFFFF, 16'h0003);
    step(1'b1, 1);
    rdc(OFS_POS, 16'hFFFF, 16'h0004);
    step(1'b0, 1);
    print_verdict();
  end
endmodule : quadrature_decoder_control_tb
